// ---- design/dma_pkg.sv ----
// constants and types shared by the four-channel dma control and status block
package dma_pkg;
    localparam int          NUM_CH       = 4;
    // register indices within a channel; byte address is four times the index
    localparam logic [4:0]  IDX_A_CNT    = 5'h00;
    localparam logic [4:0]  IDX_A_START  = 5'h04;
    localparam logic [4:0]  IDX_B_CNT    = 5'h08;
    localparam logic [4:0]  IDX_B_START  = 5'h0C;
    localparam logic [4:0]  IDX_LEN_CNT  = 5'h10;
    localparam logic [4:0]  IDX_LEN_RLD  = 5'h14;
    localparam logic [4:0]  IDX_CTRL     = 5'h1C;
    localparam logic [4:0]  IDX_STAT     = 5'h1E;
    // channel_control field positions
    localparam int          CB_CHANNEL_ENABLE      = 0;
    localparam int          CB_TC_IE     = 1;
    localparam int          CB_OVR_IE    = 2;
    localparam int          CB_SIZE      = 3;
    localparam int          CB_M2M       = 4;
    localparam int          CB_DIR       = 5;
    localparam int          CB_AUTO      = 6;
    localparam int          CB_BURST     = 7;
    localparam int          CB_SOFTWARE_REQUEST      = 8;
    localparam int          CB_A_UPD     = 9;
    localparam int          CB_A_STEP    = 10;
    localparam int          CB_B_UPD     = 12;
    localparam int          CB_B_STEP    = 14;
    localparam logic [15:0] CTRL_WMASK   = 16'hDFFF;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    // channel_status field positions
    localparam int          SB_TC        = 0;
    localparam int          SB_OVR       = 1;
    localparam int          SB_CHANNEL_ACTIVE      = 2;
    localparam int          SB_VLD       = 3;
    localparam logic [15:0] LEN_MAX      = 16'hFFFF;
    localparam logic [15:0] LEN_RST      = 16'h0000;
    localparam logic [23:0] ADDR_RST     = 24'h000000;
    localparam logic [1:0]  STEP_INC1    = 2'h0;
    localparam logic [1:0]  STEP_INC2    = 2'h1;
    localparam logic [1:0]  STEP_DEC1    = 2'h2;
    localparam logic [1:0]  STEP_DEC2    = 2'h3;

    typedef enum {ST_IDLE, ST_XFER, ST_GAP} eng_state_type;

    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] code);
        logic [23:0] r;
        r = a;
        unique case (code)
            STEP_INC1: r = a + 24'h000001;
            STEP_INC2: r = a + 24'h000002;
            STEP_DEC1: r = a - 24'h000001;
            STEP_DEC2: r = a - 24'h000002;
        endcase
        return r;
    endfunction : step_addr
endpackage : dma_pkg

// ---- design/dma_channel_control_status.sv ----
// four-channel dma control, status and transfer sequencing with an apb register port
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] counter drops by one per transfer
// [R2] zero length means 65535 transfers
// [R3] reload write sets valid flag
// [R4] size bit: 0 byte, 1 word
// [R5] direction bit picks read or write
// [R6] type bit: buffered or auto-initialize
// [R7] burst holds bus, else release each
// [R8] software keeps burst off for hardware requests
// [R9] software request bit raises request
// [R10] change software request only when inactive
// [R11] enable write 1 restarts; 0 halts
// [R12] all enables clear stops dma clock
// [R13] a pointer steps by code when enabled
// [R14] b pointer steps by same codes
// [R15] type bit: fly-by or memory-to-memory
// [R16] fly-by size must match bus width
// [R17] interrupt from flag and its enable
// [R18] control resets to zero
// [R19] sticky flags cleared by writing one
// [R20] terminal count set at block end
// [R21] overrun rule depends on mode
// [R22] active reads enabled and not finished
// [R23] block end reloads counters, clears valid
// [R24] buffered: no valid stops with overrun
// [R25] auto-initialize reloads and repeats
// [R26] freeze halts, then resumes
// [R27] four identical independent channels
module dma_channel_control_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [3:0]  hw_request,
    input  wire logic        freeze,
    input  wire logic        bus_done,
    output var  logic        bus_valid,
    output var  logic        bus_own,
    output var  logic [1:0]  bus_channel,
    output var  logic [23:0] bus_addr_a,
    output var  logic [23:0] bus_addr_b,
    output var  logic        bus_dir_write,
    output var  logic        bus_word,
    output var  logic        bus_m2m,
    output var  logic [3:0]  irq,
    output var  logic        dma_clock_run
);
    localparam int N = dma_pkg::NUM_CH;
    logic [23:0]               a_cnt_r   [N];
    logic [23:0]               a_start_r [N];
    logic [23:0]               b_cnt_r   [N];
    logic [23:0]               b_start_r [N];
    logic [15:0]               len_cnt_r [N];
    logic [15:0]               len_rld_r [N];
    logic [15:0]               ctrl_r    [N];
    logic [N-1:0]              tc_r;
    logic [N-1:0]              ovr_r;
    logic [N-1:0]              vld_r;
    logic [N-1:0]              halt_r;
    logic [N-1:0]              channel_active;
    logic [N-1:0]              elig;
    logic [N-1:0]              done_v;
    logic [N-1:0]              blk_end_v;
    logic [N-1:0]              hw_meta_r;
    logic [N-1:0]              hw_sync_r;
    logic                      frz_meta_r;
    logic                      frz_sync_r;
    dma_pkg::eng_state_type    state_r;
    dma_pkg::eng_state_type    state_nxt;
    logic [1:0]                owner_r;
    logic [1:0]                owner_nxt;
    logic                      addr_ok;
    logic                      setup;
    logic                      wr_en;
    logic [1:0]                a_ch;
    logic [4:0]                a_reg;
    logic [31:0]               rd_data;
    // hw_request and freeze pass two flip-flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hw_meta_r  <= '0;
            hw_sync_r  <= '0;
            frz_meta_r <= 1'b0;
            frz_sync_r <= 1'b0;
        end
        else
        begin
            hw_meta_r  <= hw_request;
            hw_sync_r  <= hw_meta_r;
            frz_meta_r <= freeze;
            frz_sync_r <= frz_meta_r;
        end
    end
    // apb decode: index = paddr[8:2], channel in index[6:5]
    assign a_ch  = paddr[8:7];
    assign a_reg = paddr[6:2];
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;

    always_comb
    begin
        unique case (a_reg)
            dma_pkg::IDX_A_CNT, dma_pkg::IDX_A_START, dma_pkg::IDX_B_CNT,
            dma_pkg::IDX_B_START, dma_pkg::IDX_LEN_CNT, dma_pkg::IDX_LEN_RLD,
            dma_pkg::IDX_CTRL, dma_pkg::IDX_STAT: addr_ok = (paddr[1:0] == 2'h0) & (paddr[11:9] == 3'h0);
            default:                                addr_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        rd_data = 32'h00000000;
        unique case (a_reg)
            dma_pkg::IDX_A_CNT:   rd_data = {8'h00, a_cnt_r[a_ch]};
            dma_pkg::IDX_A_START: rd_data = {8'h00, a_start_r[a_ch]};
            dma_pkg::IDX_B_CNT:   rd_data = {8'h00, b_cnt_r[a_ch]};
            dma_pkg::IDX_B_START: rd_data = {8'h00, b_start_r[a_ch]};
            dma_pkg::IDX_LEN_CNT: rd_data = {16'h0000, len_cnt_r[a_ch]};
            dma_pkg::IDX_LEN_RLD: rd_data = {16'h0000, len_rld_r[a_ch]};
            dma_pkg::IDX_CTRL:    rd_data = {16'h0000, ctrl_r[a_ch]};
            dma_pkg::IDX_STAT:    rd_data = {28'h0000000, vld_r[a_ch], channel_active[a_ch], ovr_r[a_ch], tc_r[a_ch]}; // R19
            default:              rd_data = 32'h00000000;
        endcase
    end
    // zero-wait slave: answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            prdata  <= (setup & ~pwrite & addr_ok) ? rd_data : 32'h00000000;
        end
    end
    for (genvar g = 0; g < N; g++) // R27
    begin : g_ch
        logic [15:0] cnt_dec;
        logic        w_ctrl;
        logic        w_stat;
        logic        w_rld;
        logic        auto_m;
        logic        reload;
        logic        stop;
        logic        set_tc;
        logic        set_ovr;
        assign w_ctrl    = wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_CTRL);
        assign w_stat    = wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_STAT);
        assign w_rld     = wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_LEN_RLD);
        assign auto_m    = ctrl_r[g][dma_pkg::CB_AUTO]; // R6
        assign cnt_dec   = (len_cnt_r[g] == 16'h0000) ? dma_pkg::LEN_MAX - 16'h0001 : len_cnt_r[g] - 16'h0001; // R1 R2
        assign done_v[g] = (state_r == dma_pkg::ST_XFER) & bus_done & (owner_r == 2'(g));
        assign blk_end_v[g] = done_v[g] & (cnt_dec == 16'h0000);
        assign reload    = blk_end_v[g] & (auto_m | vld_r[g]); // R24 R25
        assign stop      = blk_end_v[g] & ~auto_m & ~vld_r[g]; // R24
        assign set_tc    = blk_end_v[g] & (~auto_m | ~tc_r[g]); // R20 R25
        assign set_ovr   = blk_end_v[g] & (auto_m ? tc_r[g] : ~vld_r[g]); // R21
        assign channel_active[g]   = ctrl_r[g][dma_pkg::CB_CHANNEL_ENABLE] & ~halt_r[g]; // R22
        assign elig[g]   = channel_active[g] & ~frz_sync_r & (hw_sync_r[g] | ctrl_r[g][dma_pkg::CB_SOFTWARE_REQUEST]); // R9 R11 R26

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                a_cnt_r[g]   <= dma_pkg::ADDR_RST;
                b_cnt_r[g]   <= dma_pkg::ADDR_RST;
                len_cnt_r[g] <= dma_pkg::LEN_RST;
            end
            else
            begin
                if (wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_A_CNT))
                    a_cnt_r[g] <= pwdata[23:0];
                else if (reload)
                    a_cnt_r[g] <= a_start_r[g]; // R23
                else if (done_v[g] & ctrl_r[g][dma_pkg::CB_A_UPD])
                    a_cnt_r[g] <= dma_pkg::step_addr(a_cnt_r[g], ctrl_r[g][dma_pkg::CB_A_STEP +: 2]); // R13
                if (wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_B_CNT))
                    b_cnt_r[g] <= pwdata[23:0];
                else if (reload & ctrl_r[g][dma_pkg::CB_M2M])
                    b_cnt_r[g] <= b_start_r[g]; // R23
                else if (done_v[g] & ctrl_r[g][dma_pkg::CB_B_UPD] & ctrl_r[g][dma_pkg::CB_M2M])
                    b_cnt_r[g] <= dma_pkg::step_addr(b_cnt_r[g], ctrl_r[g][dma_pkg::CB_B_STEP +: 2]); // R14
                if (wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_LEN_CNT))
                    len_cnt_r[g] <= pwdata[15:0];
                else if (reload)
                    len_cnt_r[g] <= len_rld_r[g]; // R23
                else if (done_v[g])
                    len_cnt_r[g] <= cnt_dec; // R1
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                a_start_r[g] <= dma_pkg::ADDR_RST;
                b_start_r[g] <= dma_pkg::ADDR_RST;
                len_rld_r[g] <= dma_pkg::LEN_RST;
                ctrl_r[g]    <= dma_pkg::CTRL_RST; // R18
            end
            else
            begin
                if (wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_A_START))
                    a_start_r[g] <= pwdata[23:0];
                if (wr_en & (a_ch == 2'(g)) & (a_reg == dma_pkg::IDX_B_START))
                    b_start_r[g] <= pwdata[23:0];
                if (w_rld)
                    len_rld_r[g] <= pwdata[15:0];
                if (w_ctrl)
                    ctrl_r[g] <= pwdata[15:0] & dma_pkg::CTRL_WMASK; // R18
            end
        end
        // sticky flags: a set in the clearing cycle wins
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                tc_r[g]   <= 1'b0;
                ovr_r[g]  <= 1'b0;
                vld_r[g]  <= 1'b0;
                halt_r[g] <= 1'b0;
                irq[g]    <= 1'b0;
            end
            else
            begin
                tc_r[g]   <= (tc_r[g] & ~(w_stat & pwdata[dma_pkg::SB_TC])) | set_tc; // R19 R20
                ovr_r[g]  <= (ovr_r[g] & ~(w_stat & pwdata[dma_pkg::SB_OVR])) | set_ovr; // R19 R21
                vld_r[g]  <= (vld_r[g] & ~(w_stat & pwdata[dma_pkg::SB_VLD]) & ~reload) | w_rld; // R3 R23
                if (w_ctrl & pwdata[dma_pkg::CB_CHANNEL_ENABLE])
                    halt_r[g] <= 1'b0; // R11
                else if (stop)
                    halt_r[g] <= 1'b1; // R24
                irq[g]    <= (tc_r[g] & ctrl_r[g][dma_pkg::CB_TC_IE])
                           | (ovr_r[g] & ctrl_r[g][dma_pkg::CB_OVR_IE]); // R17
            end
        end
    end
    // transfer sequencer: lowest channel number wins the bus
    always_comb
    begin
        state_nxt = state_r;
        owner_nxt = owner_r;
        unique case (state_r)
            dma_pkg::ST_IDLE:
            begin
                for (int i = N - 1; i >= 0; i--)
                begin
                    if (elig[i])
                    begin
                        state_nxt = dma_pkg::ST_XFER;
                        owner_nxt = 2'(i);
                    end
                end
            end
            dma_pkg::ST_XFER:
                if (bus_done)
                    state_nxt = (ctrl_r[owner_r][dma_pkg::CB_BURST] & elig[owner_r])
                              ? dma_pkg::ST_GAP : dma_pkg::ST_IDLE; // R7
            dma_pkg::ST_GAP:
                state_nxt = elig[owner_r] ? dma_pkg::ST_XFER : dma_pkg::ST_IDLE; // R7 R26
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r       <= dma_pkg::ST_IDLE;
            owner_r       <= 2'h0;
            bus_valid     <= 1'b0;
            bus_own       <= 1'b0;
            bus_channel   <= 2'h0;
            bus_addr_a    <= dma_pkg::ADDR_RST;
            bus_addr_b    <= dma_pkg::ADDR_RST;
            bus_dir_write <= 1'b0;
            bus_word      <= 1'b0;
            bus_m2m       <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            owner_r   <= owner_nxt;
            bus_valid <= (state_nxt == dma_pkg::ST_XFER);
            bus_own   <= (state_nxt != dma_pkg::ST_IDLE); // R7
            if (state_nxt == dma_pkg::ST_XFER)
            begin
                bus_channel   <= owner_nxt;
                bus_addr_a    <= a_cnt_r[owner_nxt];
                bus_addr_b    <= b_cnt_r[owner_nxt];
                bus_dir_write <= ctrl_r[owner_nxt][dma_pkg::CB_DIR]; // R5
                bus_word      <= ctrl_r[owner_nxt][dma_pkg::CB_SIZE]; // R4
                bus_m2m       <= ctrl_r[owner_nxt][dma_pkg::CB_M2M]; // R15
            end
        end
    end
    // clock gate request for the dma clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dma_clock_run <= 1'b0;
        else
            dma_clock_run <= ctrl_r[0][dma_pkg::CB_CHANNEL_ENABLE] | ctrl_r[1][dma_pkg::CB_CHANNEL_ENABLE]
                           | ctrl_r[2][dma_pkg::CB_CHANNEL_ENABLE] | ctrl_r[3][dma_pkg::CB_CHANNEL_ENABLE]; // R12
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_dec;
        done_v[0] & ~blk_end_v[0] & (len_cnt_r[0] != 16'h0000) |=> len_cnt_r[0] == $past(len_cnt_r[0]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("counter did not drop by one"); // R1
    property p_zero;
        done_v[3] & (len_cnt_r[3] == 16'h0000) |=> len_cnt_r[3] == 16'hFFFE;
    endproperty
    a_zero: assert property (p_zero) else $error("zero length not taken as 65535"); // R2
    property p_vld_set;
        wr_en & (a_ch == 2'h0) & (a_reg == dma_pkg::IDX_LEN_RLD) |=> vld_r[0];
    endproperty
    a_vld_set: assert property (p_vld_set) else $error("reload write left valid clear"); // R3
    property p_sticky;
        tc_r[0] & ~(wr_en & (a_reg == dma_pkg::IDX_STAT) & (a_ch == 2'h0)) |=> tc_r[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("terminal count dropped by itself"); // R19
    property p_stop;
        blk_end_v[0] & ~ctrl_r[0][dma_pkg::CB_AUTO] & ~vld_r[0] & ~wr_en |=> ~channel_active[0] & ovr_r[0] & tc_r[0];
    endproperty
    a_stop: assert property (p_stop) else $error("buffered block end without valid did not stop"); // R24
    property p_auto_ovr;
        blk_end_v[2] & ctrl_r[2][dma_pkg::CB_AUTO] & tc_r[2] & channel_active[2] & ~wr_en |=> ovr_r[2] & channel_active[2];
    endproperty
    a_auto_ovr: assert property (p_auto_ovr) else $error("auto mode overrun missed"); // R21
    property p_irq;
        tc_r[0] & ctrl_r[0][dma_pkg::CB_TC_IE] |=> irq[0];
    endproperty
    a_irq: assert property (p_irq) else $error("terminal count interrupt missing"); // R17
    property p_release;
        (state_r == dma_pkg::ST_XFER) & bus_done & ~ctrl_r[owner_r][dma_pkg::CB_BURST] |=> ~bus_own ##1 1'b1;
    endproperty
    a_release: assert property (p_release) else $error("bus kept without burst"); // R7
    property p_freeze;
        frz_sync_r & (state_r == dma_pkg::ST_IDLE) |=> ~bus_valid;
    endproperty
    a_freeze: assert property (p_freeze) else $error("transfer started under freeze"); // R26
    property p_clk;
        (ctrl_r[0][0] | ctrl_r[1][0] | ctrl_r[2][0] | ctrl_r[3][0]) == 1'b0 |=> ~dma_clock_run;
    endproperty
    a_clk: assert property (p_clk) else $error("clock runs with all channels off"); // R12
    c_auto: cover property (blk_end_v[0] & ctrl_r[0][dma_pkg::CB_AUTO]);
    c_burst: cover property (state_r == dma_pkg::ST_GAP);
    c_stop: cover property (blk_end_v[1] & ~vld_r[1]);
endmodule : dma_channel_control_status
`default_nettype wire

// ---- dv/dma_bus_responder.sv ----
// bus responder model: ends each requested transfer cycle after lat waiting cycles
`timescale 1ns/1ps
`default_nettype none
module dma_bus_responder (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       bus_valid,
    input  wire logic       bus_own,
    input  wire logic       bus_dir_write,
    input  wire logic       bus_word,
    input  wire logic       bus_m2m,
    input  wire logic [7:0] lat,
    output var  logic       bus_done,
    output var  int         n_done,
    output var  int         n_gap,
    output var  logic [2:0] seen_mode
);
    logic [7:0] wait_r;

    // one done pulse per requested cycle, none while idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r    <= 8'h00;
            bus_done  <= 1'h0;
            n_done    <= 0;
            seen_mode <= 3'h0;
        end
        else if (bus_valid && !bus_done && wait_r >= lat)
        begin
            wait_r    <= 8'h00;
            bus_done  <= 1'h1;
            n_done    <= n_done + 1;
            seen_mode <= {bus_m2m, bus_dir_write, bus_word};
        end
        else
        begin
            wait_r   <= (bus_valid && !bus_done) ? wait_r + 8'h01 : 8'h00;
            bus_done <= 1'h0;
        end
    end

    // cycles where the bus is kept between transfers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            n_gap <= 0;
        else if (bus_own && !bus_valid)
            n_gap <= n_gap + 1;
    end
endmodule : dma_bus_responder
`default_nettype wire

// ---- dv/tb_dma_channel_control_status.sv ----
// self-checking bench for the four-channel dma control and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_dma_channel_control_status;
    localparam logic [4:0] ST = dma_pkg::IDX_STAT;
    localparam logic [4:0] CT = dma_pkg::IDX_CTRL;
    localparam logic [4:0] LC = dma_pkg::IDX_LEN_CNT;
    localparam logic [4:0] LR = dma_pkg::IDX_LEN_RLD;
    localparam logic [4:0] AC = dma_pkg::IDX_A_CNT;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  hw_request;
    logic        freeze;
    logic        bus_done;
    logic        bus_valid;
    logic        bus_own;
    logic        bus_dir_write;
    logic        bus_word;
    logic        bus_m2m;
    logic [3:0]  irq;
    logic        dma_clock_run;
    logic [23:0] bus_addr_a;
    logic [23:0] bus_addr_b;
    logic [1:0]  bus_channel;
    logic [7:0]  lat;
    logic [2:0]  seen_mode;
    logic [31:0] rd;
    logic        err;
    logic [23:0] step;
    logic [1:0]  code;
    logic        upd;
    int          n_done;
    int          n_gap;
    int          error_cnt;
    int          n_tests;
    int          base;
    int          n1;

    dma_channel_control_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_request(hw_request), .freeze(freeze), .bus_done(bus_done), .bus_valid(bus_valid), .bus_own(bus_own),
        .bus_channel(bus_channel), .bus_addr_a(bus_addr_a), .bus_addr_b(bus_addr_b),
        .bus_dir_write(bus_dir_write), .bus_word(bus_word),
        .bus_m2m(bus_m2m), .irq(irq), .dma_clock_run(dma_clock_run));
    dma_bus_responder resp (.pclk(pclk), .presetn(presetn), .bus_valid(bus_valid), .bus_own(bus_own),
        .bus_dir_write(bus_dir_write), .bus_word(bus_word), .bus_m2m(bus_m2m), .lat(lat),
        .bus_done(bus_done), .n_done(n_done), .n_gap(n_gap), .seen_mode(seen_mode));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] d);
        apb(1'h1, {3'h0, ch, idx, 2'h0}, d);
    endtask : wr

    task automatic rchk(input string nm, input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] e);
        apb(1'h0, {3'h0, ch, idx, 2'h0}, 32'h0);
        `CHK(nm, e, rd)
    endtask : rchk

    task automatic wait_idle(input logic [1:0] ch);
        do
            apb(1'h0, {3'h0, ch, ST, 2'h0}, 32'h0);
        while (rd[dma_pkg::SB_CHANNEL_ACTIVE] !== 1'h0);
    endtask : wait_idle

    task automatic wait_done(input int t);
        while (n_done < t)
            @(posedge pclk);
    endtask : wait_done

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    initial
    begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        results();
    end

    initial
    begin
        presetn    = 1'h0;
        psel       = 1'h0;
        penable    = 1'h0;
        pwrite     = 1'h0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        hw_request = 4'h0;
        freeze     = 1'h0;
        lat        = 8'h02;
        error_cnt  = 0;
        n_tests    = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rchk("ctrl_rst", 2'h0, CT, 32'h0);
        rchk("stat_rst", 2'h3, ST, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        `CHK("unmapped", 1'h1, err)
        wr(2'h0, LR, 32'h5);
        rchk("vld_set", 2'h0, ST, 32'h8);
        wr(2'h0, ST, 32'h4);
        rchk("w0_keep", 2'h0, ST, 32'h8);
        wr(2'h0, ST, 32'h8);
        rchk("w1c", 2'h0, ST, 32'h0);
        // single block of three, pointer +2 each
        wr(2'h0, AC, 32'h100);
        wr(2'h0, LC, 32'h3);
        base = n_done;
        wr(2'h0, CT, 32'h0703);
        wait_idle(2'h0);
        `CHK("xfers", 3, n_done - base)
        rchk("a_step", 2'h0, AC, 32'h106);
        rchk("len_end", 2'h0, LC, 32'h0);
        rchk("stop", 2'h0, ST, 32'h3);
        `CHK("irq_tc", 1'h1, irq[0])
        wr(2'h0, ST, 32'h1);
        repeat (3) @(posedge pclk);
        `CHK("irq_clr", 1'h0, irq[0])
        // every step code on both pointers, then updates off
        for (int i = 0; i < 5; i++)
        begin
            code = 2'(i);
            upd  = (i < 4);
            step = code[1] ? (code[0] ? 24'hFFFFFE : 24'hFFFFFF) : (code[0] ? 24'h2 : 24'h1);
            wr(2'h0, ST, 32'h3);
            wr(2'h0, AC, 32'h1000);
            wr(2'h0, dma_pkg::IDX_B_CNT, 32'h2000);
            wr(2'h0, LC, 32'h1);
            wr(2'h0, CT, 32'h111 | 32'(code[0]) << 3 | 32'(code[1]) << 5 | 32'(upd) << 9
               | 32'(code) << 10 | 32'(upd) << 12 | 32'(code) << 14);
            wait_idle(2'h0);
            rchk("a_ptr", 2'h0, AC, {8'h0, 24'h1000 + (upd ? step : 24'h0)});
            rchk("b_ptr", 2'h0, dma_pkg::IDX_B_CNT, {8'h0, 24'h2000 + (upd ? step : 24'h0)});
            `CHK("mode", {1'h1, code[1], code[0]}, seen_mode)
            `CHK("addr_a", 24'h1000, bus_addr_a)
            `CHK("addr_b", 24'h2000, bus_addr_b)
        end
        wr(2'h0, CT, 32'h0);
        // two chained blocks on a hardware request
        wr(2'h1, AC, 32'h400);
        wr(2'h1, dma_pkg::IDX_A_START, 32'h500);
        wr(2'h1, LC, 32'h2);
        wr(2'h1, LR, 32'h2);
        base = n_done;
        wr(2'h1, CT, 32'h205);
        hw_request <= 4'h2;
        wait_idle(2'h1);
        hw_request <= 4'h0;
        `CHK("dbl_xfers", 4, n_done - base)
        rchk("dbl_ptr", 2'h1, AC, 32'h502);
        `CHK("dbl_addr", 24'h501, bus_addr_a)
        `CHK("dbl_chan", 2'h1, bus_channel)
        rchk("dbl_stat", 2'h1, ST, 32'h3);
        `CHK("irq_ovr", 1'h1, irq[1])
        `CHK("no_gap", 0, n_gap)
        wr(2'h1, CT, 32'h0);
        // auto-initialize in burst on a software request
        wr(2'h2, LC, 32'h1);
        wr(2'h2, LR, 32'h1);
        base = n_done;
        wr(2'h2, CT, 32'h1C1);
        wait_done(base + 3);
        `CHK("clk_run", 1'h1, dma_clock_run)
        rchk("auto_stat", 2'h2, ST, 32'h7);
        `CHK("burst_gap", 1'h1, n_gap > 0)
        wr(2'h2, CT, 32'h0);
        repeat (4) @(posedge pclk);
        `CHK("clk_stop", 1'h0, dma_clock_run)
        // zero length, frozen mid-block, then resumed
        lat  <= 8'h14;
        base = n_done;
        wr(2'h3, LC, 32'h0);
        wr(2'h3, CT, 32'h101);
        wait_done(base + 1);
        rchk("len_zero", 2'h3, LC, 32'hFFFE);
        freeze <= 1'h1;
        repeat (60) @(posedge pclk);
        n1 = n_done;
        repeat (60) @(posedge pclk);
        `CHK("frozen", n1, n_done)
        rchk("active", 2'h3, ST, 32'h4);
        rchk("len_hold", 2'h3, LC, {16'h0, 16'hFFFF - 16'(n1 - base)});
        freeze <= 1'h0;
        wait_done(n1 + 1);
        `CHK("resume", n1 + 1, n_done)
        wr(2'h3, CT, 32'h0);
        results();
    end
endmodule : tb_dma_channel_control_status
`default_nettype wire
